// file: logic/arw_pkg.sv
package arw_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [5:0] IDX_WIN_MODE   = 6'h04;
  localparam logic [5:0] IDX_IRQ_MASK   = 6'h0a;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h0b;
  localparam logic [5:0] IDX_DEBUG_RUN  = 6'h0c;
  localparam logic [5:0] IDX_STAGING    = 6'h0d;
  localparam logic [5:0] IDX_CONV_LO    = 6'h10;
  localparam logic [5:0] IDX_CONV_HI    = 6'h11;
  localparam logic [5:0] IDX_WINLO_LO   = 6'h12;
  localparam logic [5:0] IDX_WINLO_HI   = 6'h13;
  localparam logic [5:0] IDX_WINHI_LO   = 6'h14;
  localparam logic [5:0] IDX_WINHI_HI   = 6'h15;
  localparam logic [5:0] IDX_CLK_SHAPE  = 6'h16;

  // Reset values
  localparam logic [7:0]  RST_DEBUG_RUN = 8'h00;
  localparam logic [7:0]  RST_STAGING   = 8'h00;
  localparam logic [15:0] RST_CONV      = 16'h0000;
  localparam logic [15:0] RST_WIN_LIMIT = 16'h0000;
  localparam logic        RST_DUTY      = 1'b1;
  localparam logic [2:0]  RST_WIN_MODE  = 3'h0;
  localparam logic [2:0]  RST_ACC_SEL   = 3'h0;
  localparam logic [2:0]  RST_IRQ       = 3'h0;

  // Field positions
  localparam int unsigned POS_RESULT_READY = 0;
  localparam int unsigned POS_WINDOW_MATCH = 1;
  localparam int unsigned POS_FROZEN       = 2;
  localparam int unsigned POS_KEEP_RUN     = 0;
  localparam int unsigned POS_DUTY         = 0;
  localparam int unsigned POS_WIN_MODE     = 0;
  localparam int unsigned POS_ACC_SEL      = 4;

  // Window comparator modes
  localparam logic [2:0] WIN_NONE    = 3'h0;
  localparam logic [2:0] WIN_BELOW   = 3'h1;
  localparam logic [2:0] WIN_ABOVE   = 3'h2;
  localparam logic [2:0] WIN_INSIDE  = 3'h3;
  localparam logic [2:0] WIN_OUTSIDE = 3'h4;

  // Conversion limits
  localparam logic [9:0]  CODE_MAX    = 10'h3ff;
  localparam logic [9:0]  CODE_MIN    = 10'h000;
  localparam logic [2:0]  ACC_SEL_MAX = 3'h6;
  localparam logic [15:0] ACC_CEILING = 16'hffc0;

  // Converter clock: four phases per period
  localparam logic [1:0] PHASE_HIGH_25 = 2'h1;
  localparam logic [1:0] PHASE_HIGH_50 = 2'h2;

endpackage

// file: logic/arw_clkgen.sv
`timescale 1ns/1ns
`default_nettype none
module arw_clkgen
  import arw_pkg::*;
#(
  parameter int unsigned PRESCALE = 4
)
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic duty_quarter_i,
  output logic      conv_clk_o
);

  typedef struct packed {
    logic [15:0] div;
    logic [1:0]  phase;
    logic        clk_out;
  } arw_cg_state_t;

  localparam logic [15:0] DIV_LAST = 16'(PRESCALE - 1);

  arw_cg_state_t q;
  arw_cg_state_t s;
  logic [1:0]    high_phases;

  always_comb
  begin
    s = q;
    // A quarter-high clock suits slow converter clocks, half for fast ones
    high_phases = duty_quarter_i ? PHASE_HIGH_25 : PHASE_HIGH_50; // R13
    if (q.div == DIV_LAST)
    begin
      s.div   = 16'h0000;
      s.phase = q.phase + 2'h1;
    end
    else
    begin
      s.div = q.div + 16'h0001;
    end
    s.clk_out = (s.phase < high_phases); // R13
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= s;
    end
  end

  assign conv_clk_o = q.clk_out;

endmodule
`default_nettype wire

// file: logic/arw_top.sv
// The Wishbone register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
// How it works
// R1 - With keep-running clear, a debug break drops sample events; the bus and converter clock keep running.
// R2 - With keep-running set, the block runs on through a debug break; the bit resets to 0.
// R3 - An 8-bit staging byte lets 16-bit values move atomically in two byte accesses.
// R4 - One staging byte serves all 16-bit registers, is directly readable and writable, resets to 0.
// R5 - Each 16-bit register shows bits 7:0 at its base and bits 15:8 at base plus one.
// R6 - A raw conversion is 10 bits wide in bits 9:0 of the conversion value.
// R7 - A single conversion saturates to 0x3FF above reference and 0x000 below ground.
// R8 - An accumulated sum of up to 64 samples fits 16 bits and never exceeds 0xFFC0.
// R9 - Results use an unsigned code, 0x0000 zero and 0x03FF full scale per sample, 0xFFC0 for a 64-sample sum.
// R10 - A writable 16-bit low limit, reset to zero, feeds the window comparator.
// R11 - A writable 16-bit high limit, reset to zero, feeds the window comparator.
// R12 - When accumulating, the window check uses only the final sum.
// R13 - The duty bit picks a 50 percent or 25 percent high converter clock; it resets to 1.
// R14 - The window-match flag sets at the end of a result that meets the mode; read or write-1 clears.
// R15 - The result-ready flag sets on each new result; read or write-1 clears, write-0 keeps.
// R16 - Low-byte read copies the high byte to staging; high-byte write stages, low-byte write commits.
// R17 - The conversion value is read-only and changes only when a result completes.
module arw_top
  import arw_pkg::*;
#(
  parameter int unsigned RAW_W    = 12,
  parameter int unsigned PRESCALE = 4
)
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    cyc_i,
  input  wire logic                    stb_i,
  input  wire logic                    we_i,
  input  wire logic [7:0]              adr_i,
  input  wire logic [3:0]              sel_i,
  input  wire logic [31:0]             dat_i,
  output logic      [31:0]             dat_o,
  output logic                         ack_o,
  output logic                         irq_o,
  input  wire logic                    debug_halt_i,
  input  wire logic                    sample_valid_i,
  input  wire logic signed [RAW_W-1:0] sample_code_i,
  output logic                         conv_clk_o
);

  typedef struct packed {
    logic        ack;
    logic [7:0]  rdata;
    logic        keep_run;
    logic [7:0]  staging;
    logic [15:0] result;
    logic [15:0] win_lo;
    logic [15:0] win_hi;
    logic        duty;
    logic [2:0]  win_mode;
    logic [2:0]  acc_sel;
    logic [1:0]  flags;
    logic [1:0]  mask;
    logic [15:0] acc;
    logic [6:0]  cnt;
  } arw_state_t;

  localparam logic signed [RAW_W-1:0] RAW_MAX =
    RAW_W'($signed({1'b0, CODE_MAX}));

  arw_state_t  q;
  arw_state_t  s;
  logic        req;
  logic        wr;
  logic        rd;
  logic [5:0]  idx;
  logic [7:0]  wbyte;
  logic [7:0]  rbyte;
  logic        frozen;
  logic [9:0]  sat;
  logic [2:0]  sel_eff;
  logic [6:0]  target;
  logic [6:0]  cnt_inc;
  logic [15:0] sum;
  logic        done;
  logic [1:0]  flag_set;
  logic [1:0]  flag_clr;

  // Window test on a finished value only
  function automatic logic win_hit(
    input logic [2:0]  mode,
    input logic [15:0] v,
    input logic [15:0] lo,
    input logic [15:0] hi
  );
    logic r;
    r = 1'b0;
    case (mode)
      WIN_BELOW:   r = (v < lo);
      WIN_ABOVE:   r = (v > hi);
      WIN_INSIDE:  r = (v > lo) && (v < hi);
      WIN_OUTSIDE: r = (v < lo) || (v > hi);
      default:     r = 1'b0;
    endcase
    return r;
  endfunction

  always_comb
  begin
    s        = q;
    flag_set = 2'b00;
    flag_clr = 2'b00;
    done     = 1'b0;

    // Bus decode; an access is taken once, in the cycle before ack
    req   = cyc_i && stb_i && !q.ack;
    idx   = adr_i[7:2];
    wr    = req && we_i && sel_i[0];
    rd    = req && !we_i;
    wbyte = dat_i[7:0];
    s.ack = req;

    // Debug break gate
    frozen = debug_halt_i && !q.keep_run; // R1 R2

    // Saturate the raw code into 10 bits
    if (sample_code_i < 0)
    begin
      sat = CODE_MIN; // R7
    end
    else if (sample_code_i > RAW_MAX)
    begin
      sat = CODE_MAX; // R7
    end
    else
    begin
      sat = sample_code_i[9:0]; // R6
    end

    // Accumulation length is 2**sel, at most 64 samples
    sel_eff = (q.acc_sel > ACC_SEL_MAX) ? ACC_SEL_MAX : q.acc_sel;
    target  = 7'h01 << sel_eff;
    cnt_inc = q.cnt + 7'h01;
    // 64 x 0x3FF is 0xFFC0, so the 16-bit sum never wraps
    sum     = q.acc + {6'h00, sat}; // R8 R9

    if (sample_valid_i && !frozen) // R1
    begin
      if (cnt_inc == target)
      begin
        done     = 1'b1;
        s.result = sum; // R17
        s.acc    = 16'h0000;
        s.cnt    = 7'h00;
        flag_set[POS_RESULT_READY] = 1'b1; // R15
        flag_set[POS_WINDOW_MATCH] =
          win_hit(q.win_mode, sum, q.win_lo, q.win_hi); // R12 R14
      end
      else
      begin
        s.acc = sum; // R12
        s.cnt = cnt_inc;
      end
    end

    // Register reads
    rbyte = 8'h00;
    if (rd)
    begin
      case (idx)
        IDX_WIN_MODE:
        begin
          rbyte[POS_WIN_MODE +: 3] = q.win_mode;
          rbyte[POS_ACC_SEL +: 3]  = q.acc_sel;
        end
        IDX_IRQ_MASK:
        begin
          rbyte[1:0] = q.mask;
        end
        IDX_IRQ_STATUS:
        begin
          rbyte[1:0]        = q.flags;
          rbyte[POS_FROZEN] = frozen;
        end
        IDX_DEBUG_RUN:
        begin
          rbyte[POS_KEEP_RUN] = q.keep_run; // R2
        end
        IDX_STAGING:
        begin
          rbyte = q.staging; // R4
        end
        IDX_CONV_LO:
        begin
          rbyte     = q.result[7:0]; // R5
          s.staging = q.result[15:8]; // R16 R3
          flag_clr  = 2'b11; // R14 R15
        end
        IDX_WINLO_LO:
        begin
          rbyte     = q.win_lo[7:0]; // R5
          s.staging = q.win_lo[15:8]; // R16
        end
        IDX_WINHI_LO:
        begin
          rbyte     = q.win_hi[7:0]; // R5
          s.staging = q.win_hi[15:8]; // R16
        end
        IDX_CONV_HI,
        IDX_WINLO_HI,
        IDX_WINHI_HI:
        begin
          // High byte comes from the copy taken at the low-byte read
          rbyte = q.staging; // R3 R16
        end
        IDX_CLK_SHAPE:
        begin
          rbyte[POS_DUTY] = q.duty;
        end
        default:
        begin
          rbyte = 8'h00;
        end
      endcase
      s.rdata = rbyte;
    end

    // Register writes
    if (wr)
    begin
      case (idx)
        IDX_WIN_MODE:
        begin
          s.win_mode = wbyte[POS_WIN_MODE +: 3];
          s.acc_sel  = wbyte[POS_ACC_SEL +: 3];
          // A new length restarts the running sum
          s.acc      = 16'h0000;
          s.cnt      = 7'h00;
        end
        IDX_IRQ_MASK:
        begin
          s.mask = wbyte[1:0];
        end
        IDX_IRQ_STATUS:
        begin
          flag_clr = wbyte[1:0]; // R14 R15
        end
        IDX_DEBUG_RUN:
        begin
          s.keep_run = wbyte[POS_KEEP_RUN]; // R2
        end
        IDX_STAGING:
        begin
          s.staging = wbyte; // R4
        end
        IDX_WINLO_LO:
        begin
          s.win_lo = {q.staging, wbyte}; // R10 R16
        end
        IDX_WINHI_LO:
        begin
          s.win_hi = {q.staging, wbyte}; // R11 R16
        end
        IDX_WINLO_HI,
        IDX_WINHI_HI:
        begin
          s.staging = wbyte; // R16 R3
        end
        IDX_CLK_SHAPE:
        begin
          s.duty = wbyte[POS_DUTY]; // R13
        end
        default:
        begin
          // Conversion value and unmapped offsets ignore writes
          s.flags = s.flags; // R17
        end
      endcase
    end

    // A completing result wins over a clear in the same cycle
    s.flags = (q.flags & ~flag_clr) | flag_set; // R14 R15
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q          <= '0;
      q.keep_run <= RST_DEBUG_RUN[POS_KEEP_RUN]; // R2
      q.staging  <= RST_STAGING; // R4
      q.result   <= RST_CONV;
      q.win_lo   <= RST_WIN_LIMIT; // R10
      q.win_hi   <= RST_WIN_LIMIT; // R11
      q.duty     <= RST_DUTY; // R13
      q.win_mode <= RST_WIN_MODE;
      q.acc_sel  <= RST_ACC_SEL;
      q.flags    <= RST_IRQ[1:0];
      q.mask     <= RST_IRQ[1:0];
    end
    else
    begin
      q <= s;
    end
  end

  // Clock stays running through a break; only sample events are gated
  arw_clkgen #(
    .PRESCALE       (PRESCALE)
  ) u_clkgen (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .duty_quarter_i (q.duty),
    .conv_clk_o     (conv_clk_o)
  );

  assign ack_o = q.ack;
  assign dat_o = {24'h00_0000, q.rdata};
  assign irq_o = |(q.flags & q.mask);

endmodule
`default_nettype wire

// file: test/arw_checker_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module arw_checker
  import arw_pkg::*;
#(
  parameter int unsigned RAW_W    = 12,
  parameter int unsigned PRESCALE = 4
)
(
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire logic                    cyc_i,
  input wire logic                    stb_i,
  input wire logic                    we_i,
  input wire logic [7:0]              adr_i,
  input wire logic [3:0]              sel_i,
  input wire logic [31:0]             dat_i,
  input wire logic [31:0]             dat_o,
  input wire logic                    ack_o,
  input wire logic                    irq_o,
  input wire logic                    debug_halt_i,
  input wire logic                    sample_valid_i,
  input wire logic signed [RAW_W-1:0] sample_code_i,
  input wire logic                    conv_clk_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic       take;
  logic       kr_reg;
  logic       prev_reg;
  logic [7:0] run_reg;
  assign take = cyc_i && stb_i && !ack_o;
  // Keep-running shadowed from bus writes; internals are out of sight
  always_ff @(posedge clk_i)
  begin
    prev_reg <= conv_clk_o;
    run_reg  <= (conv_clk_o == prev_reg) ? run_reg + 8'h01 : 8'h01;
    if (rst_i)
      kr_reg <= 1'b0;
    else if (take && we_i && sel_i[0] && adr_i[7:2] == IDX_DEBUG_RUN)
      kr_reg <= dat_i[0];
  end
  a_ack_one_pulse:
    assert property (ack_o |=> !ack_o) else $error("ack too long");
  a_ack_next_cycle:
    assert property (take |=> ack_o) else $error("ack missing");
  a_upper_zero:
    assert property (ack_o |-> dat_o[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_unmapped_zero:
    assert property (ack_o && !$past(we_i) && $past(adr_i[7:2]) == 6'h3f
      |-> dat_o == 32'h0000_0000) else $error("unmapped read not zero");
  a_frozen_drop:
    assert property (sample_valid_i && debug_halt_i && !kr_reg && !take
      |=> !$rose(irq_o)) else $error("frozen sample taken");
  a_irq_cause:
    assert property ($rose(irq_o) |-> $past(sample_valid_i)
      || ($past(take) && $past(we_i))) else $error("irq without cause");
  a_read_clears:
    assert property (take && !we_i && adr_i[7:2] == IDX_CONV_LO
      && !sample_valid_i |=> !irq_o) else $error("read left irq");
  a_clk_high_max:
    assert property (conv_clk_o && prev_reg |-> run_reg < 2 * PRESCALE)
    else $error("converter clock high too long");
  c_frozen_sample: cover property (sample_valid_i && debug_halt_i && !kr_reg);
  c_irq_rise: cover property ($rose(irq_o));
  c_conv_read: cover property (take && !we_i && adr_i[7:2] == IDX_CONV_LO);
endmodule
bind arw_top arw_checker #(.RAW_W(RAW_W), .PRESCALE(PRESCALE)) i_chk (.*);
`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, v) \
  begin \
    checks++; \
    if ((v) !== (e)) \
    begin \
      num_errors++; \
      $display("CHECK FAILED %s exp %h got %h", n, e, v); \
    end \
  end
module testbench
  import arw_pkg::*;
;
  localparam int P = 1;
  logic               clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic               cyc_i = 1'b0;
  logic               stb_i = 1'b0;
  logic               we_i = 1'b0;
  logic [7:0]         adr_i = 8'h00;
  logic [3:0]         sel_i = 4'h1;
  logic [31:0]        dat_i = 32'h0000_0000;
  logic [31:0]        dat_o;
  logic               ack_o;
  logic               irq_o;
  logic               debug_halt_i = 1'b0;
  logic               sample_valid_i = 1'b0;
  logic signed [11:0] sample_code_i = 12'h000;
  logic               conv_clk_o;
  int                 num_errors = 0;
  int                 checks = 0;
  int                 h;
  logic [15:0]        w;
  logic [11:0]        c;
  logic [5:0]         ri [11] = '{IDX_DEBUG_RUN, IDX_STAGING, IDX_CONV_LO,
    IDX_CONV_HI, IDX_WINLO_LO, IDX_WINLO_HI, IDX_WINHI_LO, IDX_WINHI_HI,
    IDX_CLK_SHAPE, IDX_IRQ_MASK, 6'h3f};
  // Limits sit at 0x0100 and 0x0300, so these hit both strict edges
  logic [11:0]        cs [8] = '{12'hfff, 12'h800, 12'h7ff, 12'h3ff,
    12'h400, 12'h200, 12'h100, 12'h300};
  always #20 clk_i = ~clk_i;
  arw_top #(.RAW_W(12), .PRESCALE(P)) i_dut (.*);
  function automatic logic [15:0] sat(input logic [11:0] x);
    if (x[11])
      return 16'h0000;
    return (x > 12'h3ff) ? 16'h03ff : {4'h0, x};
  endfunction
  function automatic logic win(input logic [2:0] m, input logic [15:0] v);
    case (m)
      WIN_BELOW: return v < 16'h0100;
      WIN_ABOVE: return v > 16'h0300;
      WIN_INSIDE: return v > 16'h0100 && v < 16'h0300;
      WIN_OUTSIDE: return v < 16'h0100 || v > 16'h0300;
      default: return 1'b0;
    endcase
  endfunction
  task automatic wb(input logic wr, input logic [5:0] ix,
                    input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= wr;
    adr_i <= {ix, 2'b00};
    dat_i <= {24'h00_0000, d};
    do
      @(posedge clk_i);
    while (ack_o !== 1'b1 && ++n < 20);
    `CHK("ack", 1'b1, ack_o);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [5:0] ix, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, ix, d, q);
  endtask
  task automatic rd(input logic [5:0] ix, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, ix, 8'h00, q);
    `CHK($sformatf("reg %h", ix), e, q);
  endtask
  // High byte first, so the low write commits the staged pair
  task automatic wr16(input logic [5:0] ix, input logic [15:0] v);
    wr(ix + 6'h01, v[15:8]);
    wr(ix, v[7:0]);
  endtask
  task automatic smp(input int n, input logic [11:0] x);
    sample_valid_i <= 1'b1;
    sample_code_i  <= x;
    repeat (n) @(posedge clk_i);
    sample_valid_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic hilen(output int k);
    k = 0;
    while (conv_clk_o !== 1'b0) @(posedge clk_i);
    while (conv_clk_o !== 1'b1) @(posedge clk_i);
    while (conv_clk_o === 1'b1)
    begin
      @(posedge clk_i);
      k++;
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    void'($urandom(72));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (ri[i])
      rd(ri[i], {7'h00, ri[i] == IDX_CLK_SHAPE});
    $display("reset values done");
    repeat (4)
    begin
      w = 16'($urandom);
      wr16(IDX_WINLO_LO, w);
      wr16(IDX_WINHI_LO, ~w);
      rd(IDX_WINLO_LO, w[7:0]);
      rd(IDX_STAGING, w[15:8]);
      rd(IDX_WINLO_HI, w[15:8]);
      rd(IDX_WINHI_LO, ~w[7:0]);
      rd(IDX_WINHI_HI, ~w[15:8]);
    end
    wr16(IDX_CONV_LO, 16'h5aa5);
    rd(IDX_CONV_LO, 8'h00);
    rd(IDX_CONV_HI, 8'h00);
    // A write without the low byte lane must leave staging alone
    sel_i <= 4'h0;
    wr(IDX_STAGING, 8'h77);
    sel_i <= 4'h1;
    rd(IDX_STAGING, 8'h00);
    $display("limits and staging done");
    wr16(IDX_WINLO_LO, 16'h0100);
    wr16(IDX_WINHI_LO, 16'h0300);
    for (int i = 0; i < 15; i++)
    begin
      c = (i < 8) ? cs[i] : 12'($urandom);
      w = sat(c);
      wr(IDX_WIN_MODE, 8'(i % 5));
      smp(1, c);
      rd(IDX_IRQ_STATUS, {6'h00, win(3'(i % 5), w), 1'b1});
      rd(IDX_CONV_LO, w[7:0]);
      rd(IDX_CONV_HI, w[15:8]);
      rd(IDX_IRQ_STATUS, 8'h00);
    end
    smp(1, 12'h050);
    wr(IDX_IRQ_STATUS, 8'h00);
    rd(IDX_IRQ_STATUS, 8'h03);
    wr(IDX_IRQ_MASK, 8'h01);
    `CHK("irq", 1'b1, irq_o);
    wr(IDX_IRQ_MASK, 8'h00);
    `CHK("irq", 1'b0, irq_o);
    wr(IDX_IRQ_MASK, 8'h02);
    `CHK("irq", 1'b1, irq_o);
    wr(IDX_IRQ_STATUS, 8'h03);
    `CHK("irq", 1'b0, irq_o);
    $display("conversion and flags done");
    wr(IDX_WIN_MODE, 8'h62);
    rd(IDX_WIN_MODE, 8'h62);
    smp(63, 12'h7ff);
    rd(IDX_IRQ_STATUS, 8'h00);
    smp(1, 12'h7ff);
    rd(IDX_IRQ_STATUS, 8'h03);
    rd(IDX_CONV_LO, 8'hc0);
    rd(IDX_CONV_HI, 8'hff);
    $display("accumulation done");
    wr(IDX_WIN_MODE, 8'h00);
    debug_halt_i <= 1'b1;
    smp(1, 12'h123);
    rd(IDX_IRQ_STATUS, 8'h04);
    rd(IDX_CONV_LO, 8'hc0);
    wr(IDX_DEBUG_RUN, 8'h01);
    rd(IDX_DEBUG_RUN, 8'h01);
    smp(1, 12'h123);
    rd(IDX_IRQ_STATUS, 8'h01);
    rd(IDX_CONV_LO, 8'h23);
    debug_halt_i <= 1'b0;
    $display("debug break done");
    hilen(h);
    `CHK("duty", P, h);
    wr(IDX_CLK_SHAPE, 8'h00);
    hilen(h);
    `CHK("duty", 2 * P, h);
    $display("clock shape done");
    complete_run();
  end
  initial
  begin
    #400000;
    `CHK("watchdog", 1'b1, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
